// ===== csd_pkg.sv
/*
  Package for the card session sequencer: timing constants and state codes.
  Assumes a single 125 MHz core clock shared by every module of the block.
*/
// Summary of operation
// [RL1] Host raising session request ends the session through deactivation.
// [RL2] Deactivation drops card reset first, card clock 12 us later.
// [RL3] Then card I/O and both auxiliary lines are pulled low.
// [RL4] Card supply switches off last, after all lines are low.
// [RL5] Host opens a session by driving session request high to low.
// [RL6] Host holds session request high while no session runs.
// [RL7] Outside a session alert is low without card, high with card.
// [RL8] Undervoltage with card pulls alert low; released after recovery if card present.
// [RL9] In a session any fault drives alert low.
// [RL10] A fault in a session starts deactivation at once, unprompted.
// [RL11] Host raises request after fault, rereads alert after deactivation ends.
// [RL12] Card insertion is debounced for 8 ms.
// [RL13] Alert rises after insertion only when the debounce interval ends.
// [RL14] Card removal starts deactivation and drops alert at once.
// [RL15] Extraction, supply, converter and thermal conditions all count as faults.
// [RL16] Card pin current limiting raises no alert and no deactivation.
// [RL17] Activation: supply, then I/O and aux, then clock, then reset.
// [RL18] After power-up alert stays low until a card is inserted.
// [RL19] Step delay and debounce come from counters scaled by clock rate.
// [RL20] Presence dropping before debounce ends restarts the debounce count.
package csd_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_FREQ_HZ = 125_000_000;
  localparam int STEP_DELAY_US = 12;
  localparam int DEBOUNCE_MS = 8;
  localparam int STEP_CYCLES = (STEP_DELAY_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_MS * (CLK_FREQ_HZ / 1000));
  localparam int ACT_STEP_CYCLES = 1;
  localparam int CNT_W = 20;

  // ************************************************************
  // Sequencer states, one-hot
  // ************************************************************
  typedef enum logic [7:0] {
    CSD_IDLE    = 8'h01,
    CSD_ACT_VCC = 8'h02,
    CSD_ACT_IO  = 8'h04,
    CSD_ACT_CLK = 8'h08,
    CSD_ACTIVE  = 8'h10,
    CSD_DEA_RST = 8'h20,
    CSD_DEA_IO  = 8'h40,
    CSD_DEA_VCC = 8'h80
  } csd_state_t;

endpackage : csd_pkg

// ===== csd_timer_if.sv
/*
  Interface carrying a timer load/expire handshake between sequencer and timer.
  Assumes both ends run from core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
interface csd_timer_if;
  logic start;
  logic [19:0] load;
  logic done;
  modport ctrl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface : csd_timer_if
`default_nettype wire

// ===== csd_timer.sv
/*
  Down counter: loaded by a one-cycle start strobe, raises done for one cycle once the count reaches one.
  Assumes the load value is at least one.
*/
`timescale 1ns/1ps
`default_nettype none
module csd_timer (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Control
  csd_timer_if.tmr tif
);
  import csd_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic run;
    logic done;
  } csd_tmr_st_t;

  csd_tmr_st_t st;
  csd_tmr_st_t next_st;

  // ************************************************************
  // Counter
  // ************************************************************
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (tif.start) begin
      next_st.cnt = tif.load;
      next_st.run = 1'b1;
    end else if (st.run) begin
      if (st.cnt <= 20'h00001) begin
        next_st.run = 1'b0;
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt - 20'h00001;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tif.done = st.done;
endmodule : csd_timer
`default_nettype wire

// ===== csd_sequencer.sv
/*
  Card session sequencer: activation, deactivation, fault gathering, alert.
  Assumes all inputs synchronous to core_clk_i; the host keeps the session
  request high outside sessions and reopens only after deactivation ends.
*/
`timescale 1ns/1ps
`default_nettype none
module csd_sequencer (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Host side
  input wire logic session_request_n_i,
  output logic alert_n_o,
  // Card presence and monitors
  input wire logic card_presence_in_i,
  input wire logic undervoltage_lockout_i,
  input wire logic card_supply_overload_i,
  input wire logic card_supply_out_of_range_i,
  input wire logic converter_input_supply_low_i,
  input wire logic converter_output_node_overload_i,
  input wire logic overheat_i,
  input wire logic card_pin_current_limit_i,
  // Card contacts
  output logic card_supply_o,
  output logic card_reset_out_o,
  output logic card_clock_en_o,
  output logic card_io_line_en_o,
  output logic card_aux_line_1_en_o,
  output logic card_aux_line_2_en_o,
  output logic session_busy_o
);
  import csd_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    csd_state_t fsm;
    logic card_ok;        // Debounced presence
    logic [CNT_W-1:0] deb;
    logic alert_n;
    logic vcc;
    logic rst;
    logic clk_en;
    logic io_en;
    logic req_n_d;
  } csd_seq_st_t;

  csd_seq_st_t st;
  csd_seq_st_t next_st;
  logic fault;

  csd_timer_if tif ();

  csd_timer u_timer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .tif(tif)
  );

  // ************************************************************
  // Fault gathering
  // ************************************************************
  // Pin current limiting is deliberately not part of the fault set
  assign fault = !card_presence_in_i || undervoltage_lockout_i // RL15
    || card_supply_overload_i || card_supply_out_of_range_i
    || converter_input_supply_low_i || converter_output_node_overload_i
    || overheat_i; // RL16

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    next_st = st;
    next_st.req_n_d = session_request_n_i;
    tif.start = 1'b0;
    tif.load = CNT_W'(ACT_STEP_CYCLES);

    // Debounce: restart whenever presence drops; removal is immediate
    if (!card_presence_in_i) begin
      next_st.deb = '0; // RL20
      next_st.card_ok = 1'b0; // RL14
    end else if (!st.card_ok) begin
      if (st.deb >= CNT_W'(DEBOUNCE_CYCLES - 1)) begin
        next_st.card_ok = 1'b1; // RL12
      end else begin
        next_st.deb = st.deb + 20'h00001; // RL19
      end
    end

    case (st.fsm)
      CSD_IDLE: begin
        // Open only at a falling request edge with a debounced card
        if (st.req_n_d && !session_request_n_i && st.card_ok && !fault) begin
          next_st.fsm = CSD_ACT_VCC;
          next_st.vcc = 1'b1; // RL17
          tif.start = 1'b1;
        end
      end
      CSD_ACT_VCC: begin
        if (fault || session_request_n_i) begin
          next_st.fsm = CSD_DEA_RST;
          next_st.rst = 1'b0;
          tif.start = 1'b1;
          tif.load = CNT_W'(STEP_CYCLES);
        end else if (tif.done) begin
          next_st.fsm = CSD_ACT_IO;
          next_st.io_en = 1'b1; // RL17
          tif.start = 1'b1;
        end
      end
      CSD_ACT_IO: begin
        if (fault || session_request_n_i) begin
          next_st.fsm = CSD_DEA_RST;
          tif.start = 1'b1;
          tif.load = CNT_W'(STEP_CYCLES);
        end else if (tif.done) begin
          next_st.fsm = CSD_ACT_CLK;
          next_st.clk_en = 1'b1; // RL17
          tif.start = 1'b1;
        end
      end
      CSD_ACT_CLK: begin
        if (fault || session_request_n_i) begin
          next_st.fsm = CSD_DEA_RST;
          tif.start = 1'b1;
          tif.load = CNT_W'(STEP_CYCLES);
        end else if (tif.done) begin
          next_st.fsm = CSD_ACTIVE;
          next_st.rst = 1'b1; // RL17
        end
      end
      CSD_ACTIVE: begin
        // Host release or any fault: reset low first, start 12 us wait
        if (session_request_n_i || fault) begin // RL1
          next_st.fsm = CSD_DEA_RST;
          next_st.rst = 1'b0; // RL2
          tif.start = 1'b1; // RL10
          tif.load = CNT_W'(STEP_CYCLES);
        end
      end
      CSD_DEA_RST: begin
        next_st.rst = 1'b0;
        if (tif.done) begin
          next_st.fsm = CSD_DEA_IO;
          next_st.clk_en = 1'b0; // RL2
          tif.start = 1'b1;
        end
      end
      CSD_DEA_IO: begin
        if (tif.done) begin
          next_st.fsm = CSD_DEA_VCC;
          next_st.io_en = 1'b0; // RL3
          tif.start = 1'b1;
        end
      end
      CSD_DEA_VCC: begin
        if (tif.done) begin
          next_st.fsm = CSD_IDLE;
          next_st.vcc = 1'b0; // RL4
        end
      end
      default: begin
        next_st.fsm = CSD_IDLE;
        next_st.vcc = 1'b0;
        next_st.rst = 1'b0;
        next_st.clk_en = 1'b0;
        next_st.io_en = 1'b0;
      end
    endcase

    // Alert: in a session any fault; outside, debounced presence and supply
    if (st.fsm == CSD_IDLE) begin
      next_st.alert_n = next_st.card_ok && !undervoltage_lockout_i; // RL7 RL8 RL13 RL18
    end else begin
      next_st.alert_n = st.alert_n && !fault && next_st.card_ok; // RL9 RL14
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Reset leaves alert low and every card line off until a card settles
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st <= '{fsm: CSD_IDLE, req_n_d: 1'b1, default: '0}; // RL18
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign alert_n_o = st.alert_n;
  assign card_supply_o = st.vcc;
  assign card_reset_out_o = st.rst;
  assign card_clock_en_o = st.clk_en;
  assign card_io_line_en_o = st.io_en;
  assign card_aux_line_1_en_o = st.io_en;
  assign card_aux_line_2_en_o = st.io_en;
  assign session_busy_o = (st.fsm != CSD_IDLE);
endmodule : csd_sequencer
`default_nettype wire

// ===== csd_properties.sv
/* Port assertions for csd_sequencer.
   Assumes csd_pkg is compiled first and a single core clock. */
`timescale 1ns/1ps
`default_nettype none
module csd_checker
  import csd_pkg::*;
(
  // Clock, reset, host, monitors
  input wire logic core_clk_i, rst_i, session_request_n_i, alert_n_o, card_presence_in_i,
  input wire logic undervoltage_lockout_i, card_supply_overload_i, card_supply_out_of_range_i,
  input wire logic converter_input_supply_low_i, converter_output_node_overload_i, overheat_i,
  input wire logic card_pin_current_limit_i,
  // Card contacts
  input wire logic card_supply_o, card_reset_out_o, card_clock_en_o, card_io_line_en_o,
  input wire logic card_aux_line_1_en_o, card_aux_line_2_en_o, session_busy_o
);
  // ****
  // Properties
  // ****
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] step_cnt;
  logic [20:0] pres_cnt;
  logic fault;
  // Current limiting stays out: it must not count as a fault
  assign fault = undervoltage_lockout_i | card_supply_overload_i | card_supply_out_of_range_i
    | converter_input_supply_low_i | converter_output_node_overload_i | overheat_i;
  // Counters saturate so a long idle cannot wrap into a false pass
  always_ff @(posedge core_clk_i) begin
    if (rst_i || card_reset_out_o || !session_busy_o) step_cnt <= '0;
    else if ($fell(card_reset_out_o)) step_cnt <= 16'h0001;
    else if (step_cnt != '0 && step_cnt != '1) step_cnt <= step_cnt + 16'h0001;
    if (rst_i || !card_presence_in_i) pres_cnt <= '0;
    else if (pres_cnt != '1) pres_cnt <= pres_cnt + 21'h000001;
  end
  a_clk_step_delay: assert property ($fell(card_clock_en_o) && step_cnt != '0
    |-> step_cnt == STEP_CYCLES + 1) else $error("clock gate off step delay");
  a_io_after_clk: assert property ($fell(card_io_line_en_o) |-> !card_clock_en_o
    && !card_aux_line_1_en_o && !card_aux_line_2_en_o) else $error("lines low out of order");
  a_supply_last: assert property ($fell(card_supply_o) |-> !$past(card_io_line_en_o)
    && !card_clock_en_o && !card_reset_out_o) else $error("supply off too early");
  a_release_ends: assert property ($rose(session_request_n_i) && card_reset_out_o
    |-> ##[1:2] !card_reset_out_o) else $error("release ignored");
  a_fault_deact: assert property (fault && card_reset_out_o
    |-> ##[1:2] (!card_reset_out_o && !alert_n_o)) else $error("fault not acted upon");
  a_removal_drop: assert property ($fell(card_presence_in_i) |-> ##[1:2] !alert_n_o)
    else $error("alert held after removal");
  a_debounce_rise: assert property ($rose(alert_n_o)
    |-> pres_cnt >= DEBOUNCE_CYCLES - 1) else $error("alert rose early");
  a_act_order: assert property ($rose(card_clock_en_o) |-> card_io_line_en_o
    && card_supply_o && !card_reset_out_o) else $error("activation out of order");
  a_alert_por: assert property ($fell(rst_i) |-> !alert_n_o) else $error("alert high at start");
  c_deact: cover property ($fell(card_supply_o));
  c_alert: cover property ($rose(alert_n_o));
  c_active: cover property ($rose(card_reset_out_o));
endmodule : csd_checker
bind csd_sequencer csd_checker chk (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .session_request_n_i(session_request_n_i),
  .alert_n_o(alert_n_o),
  .card_presence_in_i(card_presence_in_i),
  .undervoltage_lockout_i(undervoltage_lockout_i),
  .card_supply_overload_i(card_supply_overload_i),
  .card_supply_out_of_range_i(card_supply_out_of_range_i),
  .converter_input_supply_low_i(converter_input_supply_low_i),
  .converter_output_node_overload_i(converter_output_node_overload_i),
  .overheat_i(overheat_i),
  .card_pin_current_limit_i(card_pin_current_limit_i),
  .card_supply_o(card_supply_o),
  .card_reset_out_o(card_reset_out_o),
  .card_clock_en_o(card_clock_en_o),
  .card_io_line_en_o(card_io_line_en_o),
  .card_aux_line_1_en_o(card_aux_line_1_en_o),
  .card_aux_line_2_en_o(card_aux_line_2_en_o),
  .session_busy_o(session_busy_o)
);
`default_nettype wire

// ===== csd_host_model.sv
/* Host model: drives the active-low session request level.
   Assumes one-cycle open and close pulses from the bench. */
`timescale 1ns/1ps
`default_nettype none
module csd_host_model (
  // Clock, reset, bench commands
  input wire logic core_clk_i, rst_i, open_i, close_i,
  // Device side
  input wire logic alert_n_i, busy_i,
  output logic session_request_n_o
);
  // Fault raises the request at once; the bench rereads alert after idle
  always_ff @(posedge core_clk_i) begin
    if (rst_i || close_i) session_request_n_o <= 1'b1;
    else if (!alert_n_i && !session_request_n_o) session_request_n_o <= 1'b1;
    else if (open_i && !busy_i) session_request_n_o <= 1'b0;
  end
endmodule : csd_host_model
`default_nettype wire

// ===== testbench.sv
/* Self-checking bench for csd_sequencer with a host model.
   Assumes the full debounce count, so one insertion is run. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import csd_pkg::*;
  logic core_clk_i = 0, rst_i = 1, pres = 0, cur_lim = 0, open = 0, close = 0;
  logic [5:0] flt = '0;
  wire logic req_n, alert_n, sup, rst_o, clk_en, io_en, busy, aux1, aux2;
  int n_fail = 0, num_checks = 0;
  csd_sequencer uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .session_request_n_i(req_n),
    .alert_n_o(alert_n), .card_presence_in_i(pres), .undervoltage_lockout_i(flt[0]),
    .card_supply_overload_i(flt[1]), .card_supply_out_of_range_i(flt[2]),
    .converter_input_supply_low_i(flt[3]), .converter_output_node_overload_i(flt[4]),
    .overheat_i(flt[5]), .card_pin_current_limit_i(cur_lim), .card_supply_o(sup),
    .card_reset_out_o(rst_o), .card_clock_en_o(clk_en), .card_io_line_en_o(io_en),
    .card_aux_line_1_en_o(aux1), .card_aux_line_2_en_o(aux2), .session_busy_o(busy));
  csd_host_model host (.core_clk_i(core_clk_i), .rst_i(rst_i), .open_i(open),
    .close_i(close), .alert_n_i(alert_n), .busy_i(busy), .session_request_n_o(req_n));
  // ****
  // Helpers
  // ****
  initial forever #4 core_clk_i = ~core_clk_i;
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : cyc
  task automatic chk(input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // Bounded wait for the end of deactivation
  task automatic wait_idle;
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) cyc(1);
    chk(busy, 1'b0);
  endtask : wait_idle
  task automatic open_s;
    open = 1;
    cyc(1);
    open = 0;
    cyc(12);
  endtask : open_s
  // ****
  // Scenarios
  // ****
  // Short glitch first: a count that does not restart rises too early
  task automatic t_insert;
    chk(alert_n, 1'b0);
    pres = 1;
    cyc(1000);
    pres = 0;
    cyc(2);
    chk(alert_n, 1'b0);
    pres = 1;
    cyc(DEBOUNCE_CYCLES - 10);
    chk(alert_n, 1'b0);
    cyc(20);
    chk(alert_n, 1'b1);
  endtask : t_insert
  task automatic t_session;
    open_s();
    chk(rst_o, 1'b1);
    chk(aux1, 1'b1);
    cur_lim = 1;
    cyc(5);
    cur_lim = 0;
    chk(alert_n, 1'b1);
    chk(rst_o, 1'b1);
    close = 1;
    cyc(1);
    close = 0;
    cyc(3);
    chk(rst_o, 1'b0);
    cyc(STEP_CYCLES - 20);
    chk(clk_en, 1'b1);
    cyc(20);
    chk(clk_en, 1'b0);
    chk(io_en, 1'b1);
    wait_idle();
    chk(sup, 1'b0);
    chk(io_en, 1'b0);
    chk(aux1, 1'b0);
    chk(aux2, 1'b0);
  endtask : t_session
  // Each fault monitor in turn, undervoltage first
  task automatic t_faults;
    // Undervoltage outside a session, card present
    flt = 6'h01;
    cyc(1);
    chk(alert_n, 1'b0);
    flt = '0;
    cyc(2);
    chk(alert_n, 1'b1);
    for (int i = 0; i < 6; i++) begin
      open_s();
      flt = 6'h01 << i;
      cyc(1);
      flt = '0;
      chk(alert_n, 1'b0);
      chk(rst_o, 1'b0);
      wait_idle();
      cyc(3);
      chk(alert_n, 1'b1);
    end
  endtask : t_faults
  task automatic t_removal;
    open_s();
    pres = 0;
    cyc(3);
    chk(alert_n, 1'b0);
    chk(rst_o, 1'b0);
    wait_idle();
    chk(sup, 1'b0);
  endtask : t_removal
  initial begin
    cyc(3);
    rst_i = 0;
    cyc(2);
    t_insert();
    t_session();
    t_faults();
    t_removal();
    finish_test();
  end
  // Watchdog: debounce plus a generous margin for the sessions
  initial begin
    #(8 * (DEBOUNCE_CYCLES + 40000));
    n_fail++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
